// [usbs_ep0_device.sv]
// Device end: interrupt status flags, interrupt enable and endpoint 0
// control, with the handshake choices handed to the serial engine.
// Assumes the serial engine gives one-cycle event pulses on clk_sys and
// the register controller drives the register port on the same clock.
`timescale 1ns/1ps
`default_nettype none

module usbs_ep0_device
  import usbs_pkg::*;
#(
  parameter int IDLE_CYCLES = USBS_IDLE_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  usbs_reg_if.dev regs,
  // Events from the serial engine, one-cycle pulses.
  input wire logic sie_bus_reset,
  input wire logic sie_eop,
  input wire logic sie_activity,
  input wire logic sie_setup_token,
  input wire logic sie_ep0_tx_acked,
  input wire logic sie_ep0_rx_acked,
  input wire logic sie_ep12_tx_acked,
  // Endpoint 1/2 transmit enable, kept in another register.
  input wire logic ep12_transmit_enable,
  // Handshake choices for the serial engine.
  output usbs_resp_e ep0_in_resp,
  output usbs_resp_e ep0_out_resp,
  output logic ep12_in_nak,
  output logic ep0_data_sequence,
  output logic [USBS_C0_CNT_W-1:0] ep0_tx_byte_count,
  // System side.
  output logic usb_clk_stop,
  output logic usb_irq,
  output logic cpu_reset_req,
  output logic bus_idle_long
);

  localparam int IDLE_W = $clog2(IDLE_CYCLES + 1);
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYCLES);

  logic wr_status;
  logic wr_irq_en;
  logic wr_ctrl;
  logic [7:0] status;
  logic [7:0] hw_set;
  logic [7:0] sw_set;
  logic [7:0] sw_clr;
  logic [7:0] irq_en_reg;
  logic seq_reg;
  logic stall_reg;
  logic txe_reg;
  logic rxe_reg;
  logic [USBS_C0_CNT_W-1:0] cnt_reg;
  logic [7:0] rdata_reg;
  logic [IDLE_W-1:0] idle_cnt_reg;
  logic cpu_reset_reg;

  // Write decode for each register.
  assign wr_status = regs.wr && (regs.addr == USBS_OFS_STATUS);
  assign wr_irq_en = regs.wr && (regs.addr == USBS_OFS_IRQ_EN);
  assign wr_ctrl = regs.wr && (regs.addr == USBS_OFS_EP0_CTRL);

  // Hardware events per status bit; bit 6 has none and stays zero.
  always_comb begin
    hw_set = 8'h00;
    hw_set[USBS_ST_BUS_RESET] = sie_bus_reset;
    hw_set[USBS_ST_EP0_TX] = sie_ep0_tx_acked;
    hw_set[USBS_ST_EP0_RX] = sie_ep0_rx_acked;
    hw_set[USBS_ST_EP12_TX] = sie_ep12_tx_acked;
    hw_set[USBS_ST_EOP] = sie_eop;
    hw_set[USBS_ST_RESUME] = sie_activity && status[USBS_ST_SUSPEND];
  end

  // Software writes: zero clears flags 0 to 4 and one leaves them; bit 7 takes the value
  // written, and no write clears the bus reset flag.
  always_comb begin
    sw_set = 8'h00;
    sw_clr = {8{wr_status}} & ~regs.wdata & USBS_ST_W0C_MASK;
    sw_set[USBS_ST_SUSPEND] = wr_status && regs.wdata[USBS_ST_SUSPEND];
    sw_clr[USBS_ST_SUSPEND] = wr_status && !regs.wdata[USBS_ST_SUSPEND];
  end

  // One flag cell per status bit.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      usbs_flag_cell u_cell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .hw_set(hw_set[gi]),
        .sw_set(sw_set[gi]),
        .sw_clr(sw_clr[gi]),
        .flag(status[gi])
      );
    end
  endgenerate

  // The suspend flag gates the USB clock directly.
  assign usb_clk_stop = status[USBS_ST_SUSPEND];

  // Interrupt enable register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_reg <= USBS_RST_REG;
    end else if (wr_irq_en) begin
      irq_en_reg <= regs.wdata;
    end
  end

  // Any enabled flag raises the interrupt, the bus reset flag included.
  assign usb_irq = |(status & irq_en_reg & USBS_IE_IRQ_MASK);

  // Chip reset request: one pulse per bus reset while enabled. The flag
  // itself survives, since the outside reset logic decides what it clears.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_reset_reg <= 1'b0;
    end else begin
      cpu_reset_reg <= sie_bus_reset && irq_en_reg[USBS_IE_RESET_CPU];
    end
  end
  assign cpu_reset_req = cpu_reset_reg;

  // Sequence, enables and count change only by software.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= 1'b0;
      txe_reg <= 1'b0;
      rxe_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (wr_ctrl) begin
      seq_reg <= regs.wdata[USBS_C0_SEQ];
      txe_reg <= regs.wdata[USBS_C0_TXE];
      rxe_reg <= regs.wdata[USBS_C0_RXE];
      cnt_reg <= regs.wdata[USBS_C0_CNT_MSB -: USBS_C0_CNT_W];
    end
  end

  // Stall bit: a SETUP token clears it, but a software write in the same
  // cycle wins so that a fresh stall request is not dropped.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg <= 1'b0;
    end else if (wr_ctrl) begin
      stall_reg <= regs.wdata[USBS_C0_STALL];
    end else if (sie_setup_token) begin
      stall_reg <= 1'b0;
    end
  end

  // Handshake for an endpoint 0 IN token.
  always_comb begin
    if (stall_reg) begin
      ep0_in_resp = USBS_RESP_STALL;
    end else if (!txe_reg || status[USBS_ST_EP0_TX]) begin
      ep0_in_resp = USBS_RESP_NAK;
    end else begin
      ep0_in_resp = USBS_RESP_DATA;
    end
  end

  // Handshake for an endpoint 0 OUT token.
  always_comb begin
    if (stall_reg) begin
      ep0_out_resp = USBS_RESP_STALL;
    end else if (!rxe_reg || status[USBS_ST_EP0_RX]) begin
      ep0_out_resp = USBS_RESP_NAK;
    end else begin
      ep0_out_resp = USBS_RESP_DATA;
    end
  end

  // Shared endpoint 1/2 IN handshake.
  assign ep12_in_nak = !ep12_transmit_enable || status[USBS_ST_EP12_TX];

  assign ep0_data_sequence = seq_reg;
  assign ep0_tx_byte_count = cnt_reg;

  // Register read data, taken on the read strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= USBS_RST_REG;
    end else if (regs.rd) begin
      case (regs.addr)
        USBS_OFS_STATUS: rdata_reg <= status;
        USBS_OFS_IRQ_EN: rdata_reg <= irq_en_reg;
        USBS_OFS_EP0_CTRL: rdata_reg <= {seq_reg, stall_reg, txe_reg, rxe_reg, cnt_reg};
        default: rdata_reg <= USBS_RST_REG;
      endcase
    end
  end
  assign regs.rdata = rdata_reg;

  // Idle timer: tells software that the bus has been quiet long enough to
  // suspend. It saturates rather than wrapping so the level stays valid.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_reg <= '0;
    end else if (sie_activity) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != IDLE_LAST) begin
      idle_cnt_reg <= idle_cnt_reg + IDLE_W'(1);
    end
  end
  assign bus_idle_long = (idle_cnt_reg == IDLE_LAST);

endmodule : usbs_ep0_device

`default_nettype wire

// [usbs_pkg.sv]
// Package for the endpoint 0 status and control block: register offsets,
// bit positions, reset values, handshake codes and timing constants.
// Shared by the device end, the register controller end, the checker and the bench.
package usbs_pkg;

  // Byte offsets of the block's registers on its own register port.
  localparam logic [7:0] USBS_OFS_STATUS = 8'he8;
  localparam logic [7:0] USBS_OFS_IRQ_EN = 8'he9;
  localparam logic [7:0] USBS_OFS_EP0_CTRL = 8'hea;

  // Interrupt status bit positions.
  localparam int USBS_ST_SUSPEND = 7;
  localparam int USBS_ST_BUS_RESET = 5;
  localparam int USBS_ST_EP0_TX = 4;
  localparam int USBS_ST_EP0_RX = 3;
  localparam int USBS_ST_EP12_TX = 2;
  localparam int USBS_ST_EOP = 1;
  localparam int USBS_ST_RESUME = 0;

  // Status bits that software clears by writing zero.
  localparam logic [7:0] USBS_ST_W0C_MASK = 8'h1f;

  // Interrupt enable: bit 6 enables the chip reset, it is no interrupt enable.
  localparam int USBS_IE_RESET_CPU = 6;
  localparam logic [7:0] USBS_IE_IRQ_MASK = 8'hbf;

  // Endpoint 0 control bit positions and count field.
  localparam int USBS_C0_SEQ = 7;
  localparam int USBS_C0_STALL = 6;
  localparam int USBS_C0_TXE = 5;
  localparam int USBS_C0_RXE = 4;
  localparam int USBS_C0_CNT_MSB = 3;
  localparam int USBS_C0_CNT_W = 4;

  // Reset values.
  localparam logic [7:0] USBS_RST_REG = 8'h00;

  // Handshake chosen for a token.
  typedef enum logic [1:0] {
    USBS_RESP_DATA = 2'h0,
    USBS_RESP_NAK = 2'h1,
    USBS_RESP_STALL = 2'h2
  } usbs_resp_e;

  // Bus idle time after which software is expected to suspend.
  localparam int USBS_CLK_MHZ = 250;
  localparam int USBS_IDLE_TIME_US = 3000;
  localparam int USBS_IDLE_CYCLES = USBS_IDLE_TIME_US * USBS_CLK_MHZ;

  // AXI4-Lite responses and word map of the controller.
  localparam logic [1:0] USBS_AXI_OKAY = 2'h0;
  localparam logic [1:0] USBS_AXI_SLVERR = 2'h2;
  localparam logic [3:0] USBS_AXI_OFS_STATUS = 4'h0;
  localparam logic [3:0] USBS_AXI_OFS_IRQ_EN = 4'h4;
  localparam logic [3:0] USBS_AXI_OFS_EP0_CTRL = 4'h8;

endpackage : usbs_pkg

// [usbs_reg_if.sv]
// Register port between the register controller and the device end.
// Assumes one clock; reads return data one edge after the read strobe.
`timescale 1ns/1ps
`default_nettype none

interface usbs_reg_if;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;

  // Device end of the port.
  modport dev (input addr, input wr, input rd, input wdata, output rdata);
  // Controller end of the port.
  modport ctl (output addr, output wr, output rd, output wdata, input rdata);
endinterface : usbs_reg_if

`default_nettype wire

// [usbs_flag_cell.sv]
// One sticky status flag with hardware set and software set and clear.
// Assumes all inputs are on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module usbs_flag_cell (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Set and clear requests.
  input wire logic hw_set,
  input wire logic sw_set,
  input wire logic sw_clr,
  // Flag.
  output logic flag
);

  // A set in the same cycle as a clear wins, so no event is ever lost.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (hw_set || sw_set) begin
      flag <= 1'b1;
    end else if (sw_clr) begin
      flag <= 1'b0;
    end
  end

endmodule : usbs_flag_cell

`default_nettype wire

// [usbs_reg_ctl.sv]
// Register controller end: an AXI4-Lite slave that turns software accesses
// into strobes on the device's register port.
// Assumes one clock; one write and one read at most are under way.
`timescale 1ns/1ps
`default_nettype none

module usbs_reg_ctl
  import usbs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Write address channel.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device register port.
  usbs_reg_if.ctl regs
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WR = 5'h02,
    ST_RD = 5'h04,
    ST_BRESP = 5'h08,
    ST_RRESP = 5'h10
  } usbs_ctl_state_e;

  usbs_ctl_state_e state_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic aw_bad_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic [7:0] addr_reg;
  logic rd_bad_reg;
  logic [7:0] map_aw;
  logic [7:0] map_ar;

  // Word offset to device offset; zero marks an unmapped word.
  function automatic logic [7:0] map_ofs(input logic [31:0] a);
    logic [7:0] m;
    m = 8'h00;
    if (a[31:4] == 28'h0) begin
      case (a[3:0])
        USBS_AXI_OFS_STATUS: m = USBS_OFS_STATUS;
        USBS_AXI_OFS_IRQ_EN: m = USBS_OFS_IRQ_EN;
        USBS_AXI_OFS_EP0_CTRL: m = USBS_OFS_EP0_CTRL;
        default: m = 8'h00;
      endcase
    end
    return m;
  endfunction : map_ofs

  assign map_aw = map_ofs(s_axi_awaddr);
  assign map_ar = map_ofs(s_axi_araddr);

  // Handshake outputs: writes collect in idle, reads start only when no
  // write half is held or offered, so the two never interleave on the
  // register port and a read cannot overwrite a just-taken write address.
  assign s_axi_awready = (state_reg == ST_IDLE) && !aw_got_reg;
  assign s_axi_wready = (state_reg == ST_IDLE) && !w_got_reg;
  assign s_axi_arready = (state_reg == ST_IDLE) && !aw_got_reg && !w_got_reg && !s_axi_awvalid && !s_axi_wvalid;
  assign s_axi_bvalid = (state_reg == ST_BRESP);
  assign s_axi_rvalid = (state_reg == ST_RRESP);
  assign s_axi_bresp = aw_bad_reg ? USBS_AXI_SLVERR : USBS_AXI_OKAY;
  assign s_axi_rresp = rd_bad_reg ? USBS_AXI_SLVERR : USBS_AXI_OKAY;
  assign s_axi_rdata = rd_bad_reg ? 32'h0000_0000 : {24'h00_0000, regs.rdata};

  // Register port strobes; a write without the low byte lane does nothing.
  assign regs.wr = (state_reg == ST_WR) && !aw_bad_reg && wstrb0_reg;
  assign regs.rd = (state_reg == ST_RD) && !rd_bad_reg;
  assign regs.addr = addr_reg;
  assign regs.wdata = wdata_reg;

  // Sequencer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_bad_reg <= 1'b0;
      rd_bad_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_bad_reg <= (map_aw == 8'h00);
            addr_reg <= map_aw;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
          end
          if ((aw_got_reg || s_axi_awvalid) && (w_got_reg || s_axi_wvalid)) begin
            state_reg <= ST_WR;
          end else if (s_axi_arvalid && s_axi_arready) begin
            rd_bad_reg <= (map_ar == 8'h00);
            addr_reg <= map_ar;
            state_reg <= ST_RD;
          end
        end
        ST_WR: begin
          aw_got_reg <= 1'b0;
          w_got_reg <= 1'b0;
          state_reg <= ST_BRESP;
        end
        ST_RD: state_reg <= ST_RRESP;
        ST_BRESP: begin
          if (s_axi_bready) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RRESP: begin
          if (s_axi_rready) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule : usbs_reg_ctl

`default_nettype wire

// [usbs_ep0_properties.sv]
// Checker for the endpoint 0 status block: register port and handshake outputs.
// Assumes one clock, clk_sys, and rst_n active low; writes land a cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none

module usbs_ep0_properties
  import usbs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic [7:0] wdata,
  // Engine events.
  input wire logic sie_bus_reset,
  input wire logic sie_setup_token,
  input wire logic sie_ep0_tx_acked,
  input wire logic sie_ep0_rx_acked,
  input wire logic sie_ep12_tx_acked,
  // Device outputs.
  input wire usbs_resp_e ep0_in_resp,
  input wire usbs_resp_e ep0_out_resp,
  input wire logic ep12_in_nak,
  input wire logic ep0_data_sequence,
  input wire logic [3:0] ep0_tx_byte_count,
  input wire logic usb_clk_stop,
  input wire logic cpu_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Decoded register writes.
  logic wr_ctrl;
  logic wr_stat;
  assign wr_ctrl = wr && (addr == USBS_OFS_EP0_CTRL);
  assign wr_stat = wr && (addr == USBS_OFS_STATUS);

  a_stall_both_dirs: assert property (
    ep0_in_resp == USBS_RESP_STALL |-> ep0_out_resp == USBS_RESP_STALL) else $error("stall on one direction only");
  a_stall_write: assert property (
    wr_ctrl && wdata[6] |=> ep0_in_resp == USBS_RESP_STALL) else $error("stall write not honoured");
  a_setup_unstall: assert property (
    sie_setup_token && !wr_ctrl |=> ep0_in_resp != USBS_RESP_STALL) else $error("setup left stall set");
  a_count_write: assert property (
    wr_ctrl |=> ep0_tx_byte_count == $past(wdata[3:0])) else $error("byte count not written");
  a_seq_hold: assert property (
    !wr_ctrl |=> $stable(ep0_data_sequence)) else $error("sequence bit moved without a write");
  a_suspend_clock: assert property (
    wr_stat |=> usb_clk_stop == $past(wdata[7])) else $error("clock stop does not follow suspend");
  a_cpu_reset_cause: assert property (
    cpu_reset_req |-> $past(sie_bus_reset)) else $error("chip reset without bus reset");
  a_tx_ack_nak: assert property (
    sie_ep0_tx_acked |=> ep0_in_resp != USBS_RESP_DATA) else $error("IN not refused after ack");
  a_rx_ack_nak: assert property (
    sie_ep0_rx_acked |=> ep0_out_resp != USBS_RESP_DATA) else $error("OUT not refused after ack");
  a_ep12_ack_nak: assert property (
    sie_ep12_tx_acked |=> ep12_in_nak) else $error("shared IN not refused after ack");

  // Main scenarios reached.
  c_stall: cover property (ep0_in_resp == USBS_RESP_STALL);
  c_cpu_reset: cover property (cpu_reset_req);
  c_suspend: cover property ($rose(usb_clk_stop));
endmodule : usbs_ep0_properties

`default_nettype wire

// [usbs_ep0_status_control_tb.sv]
// Self-checking bench: both ends joined by the register interface, AXI4-Lite driven.
// Assumes the package map and the hand-over timing; a small idle count shortens the run.
`timescale 1ns/1ps
`default_nettype none

module usbs_ep0_status_control_tb
  import usbs_pkg::*;
;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready, e12_en, awready, wready;
  logic bvalid, arready, rvalid, ep12_nak, seq, clk_stop, irq, cpu_rst, idle_long;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] cnt, strb;
  logic [6:0] sie;
  usbs_resp_e in_resp, out_resp;
  int st, ie, c0, err_total, checks_done, seed, i, k;
  usbs_reg_if rif();

  usbs_reg_ctl usbs_reg_ctl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .regs(rif.ctl));
  usbs_ep0_device #(.IDLE_CYCLES(20)) usbs_ep0_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .regs(rif.dev),
    .sie_bus_reset(sie[0]), .sie_eop(sie[1]), .sie_activity(sie[2]), .sie_setup_token(sie[3]),
    .sie_ep0_tx_acked(sie[4]), .sie_ep0_rx_acked(sie[5]), .sie_ep12_tx_acked(sie[6]),
    .ep12_transmit_enable(e12_en), .ep0_in_resp(in_resp), .ep0_out_resp(out_resp), .ep12_in_nak(ep12_nak),
    .ep0_data_sequence(seq), .ep0_tx_byte_count(cnt), .usb_clk_stop(clk_stop), .usb_irq(irq),
    .cpu_reset_req(cpu_rst), .bus_idle_long(idle_long));
  usbs_ep0_properties usbs_ep0_properties_inst (.clk_sys(clk_sys), .rst_n(rst_n), .addr(rif.addr),
    .wr(rif.wr), .wdata(rif.wdata), .sie_bus_reset(sie[0]), .sie_setup_token(sie[3]),
    .sie_ep0_tx_acked(sie[4]), .sie_ep0_rx_acked(sie[5]), .sie_ep12_tx_acked(sie[6]),
    .ep0_in_resp(in_resp), .ep0_out_resp(out_resp), .ep12_in_nak(ep12_nak), .ep0_data_sequence(seq),
    .ep0_tx_byte_count(cnt), .usb_clk_stop(clk_stop), .cpu_reset_req(cpu_rst));

  // Free-running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_val

  // A handshake that never comes ends the run rather than hanging it.
  task hang;
    err_total++;
    $display("BAD %0t no answer on the bus", $time);
    report_and_stop();
  endtask : hang

  // Write: both halves offered together, each released once taken, then the response.
  task axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw, w, ta, tw, done;
    logic [1:0] r;
    @(posedge clk_sys);
    awaddr <= {28'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      #1;
      ta = aw && awready;
      tw = w && wready;
      done = !aw && !w && bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (ta) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
      n++;
    end
    bready <= 1'b0;
    if (!done) hang();
    cmp_val(r, er, "write response");
  endtask : axw

  // Read: address held until taken, rready held until the data is taken.
  task rreg(input logic [3:0] a);
    int n;
    logic pend, ta, done;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    araddr <= {28'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    pend = 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50) begin
      #1;
      ta = pend && arready;
      done = !pend && rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ta) begin
        arvalid <= 1'b0;
        pend = 1'b0;
      end
      n++;
    end
    rready <= 1'b0;
    if (!done) hang();
    cmp_val(d, a == 4'h0 ? st : a == 4'h4 ? ie : a == 4'h8 ? c0 : 0, "read data");
    cmp_val(r, a > 4'h8 ? USBS_AXI_SLVERR : USBS_AXI_OKAY, "read response");
  endtask : rreg

  // Writes a word and keeps the model in step; word 0xc is unmapped.
  task wreg(input logic [3:0] a, input logic [7:0] d);
    axw(a, d, a > 4'h8 ? USBS_AXI_SLVERR : USBS_AXI_OKAY);
    if (a == 4'h0) st = (d & 8'h80) | (st & 8'h20) | (st & d & 8'h1f);
    if (a == 4'h4) ie = d;
    if (a == 4'h8) c0 = d;
  endtask : wreg

  // Compares every handshake output, the byte count, the sequence bit, the clock stop and the interrupt with the model.
  task pins;
    #1;
    cmp_val(in_resp, c0[6] ? 2 : (!c0[5] || st[4]) ? 1 : 0, "IN answer");
    cmp_val(out_resp, c0[6] ? 2 : (!c0[4] || st[3]) ? 1 : 0, "OUT answer");
    cmp_val(ep12_nak, !e12_en || st[2], "shared IN refusal");
    cmp_val(cnt, c0 & 15, "byte count");
    cmp_val(seq, c0[7], "sequence bit");
    cmp_val(clk_stop, st[7], "clock stop");
    cmp_val(irq, (st & ie & 8'hbf) != 0, "interrupt");
  endtask : pins

  // One engine event pulse, then the flags, the chip reset and a status read are checked.
  task pulse(input int e);
    @(posedge clk_sys);
    sie[e] <= 1'b1;
    @(posedge clk_sys);
    sie[e] <= 1'b0;
    #1;
    cmp_val(cpu_rst, e == 0 && ie[6], "chip reset");
    if (e == 2) cmp_val(idle_long, 1'b0, "idle after activity");
    case (e)
      0: st |= 8'h20;
      1: st |= 8'h02;
      2: st |= st[7];
      3: c0 &= 8'hbf;
      4: st |= 8'h10;
      5: st |= 8'h08;
      default: st |= 8'h04;
    endcase
    pins();
    rreg(4'h0);
  endtask : pulse

  // Main sequence: reset, register table, every event, then random traffic.
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, e12_en, sie} = '0;
    {awaddr, wdata, araddr} = '0;
    strb = 4'hf;
    {st, ie, c0, err_total, checks_done} = '0;
    seed = 44;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    pins();
    for (k = 0; k < 16; k += 4) rreg(4'(k));
    $display("reset values done");
    repeat (12) begin
      e12_en <= 1'($random(seed));
      wreg(4'h8, 8'($random(seed)));
      pins();
      rreg(4'h8);
    end
    wreg(4'hc, 8'hff);
    // A write without the low byte lane is answered but must change nothing.
    strb <= 4'he;
    axw(4'h8, 8'hff, USBS_AXI_OKAY);
    strb <= 4'hf;
    pins();
    $display("control register done");
    wreg(4'h4, 8'hbf);
    wreg(4'h8, 8'h30);
    for (i = 0; i < 7; i++) pulse(i);
    wreg(4'h0, 8'h17);
    rreg(4'h0);
    wreg(4'h0, 8'h80);
    pulse(2);
    wreg(4'h0, 8'h00);
    pins();
    wreg(4'h8, 8'h40);
    pulse(3);
    wreg(4'h4, 8'h40);
    pulse(0);
    $display("event flags done");
    repeat (40) begin
      pulse({$random(seed)} % 7);
      e12_en <= 1'($random(seed));
      wreg(4'({$random(seed)} % 4 * 4), 8'($random(seed)));
      pins();
    end
    $display("random traffic done");
    repeat (30) @(posedge clk_sys);
    #1;
    cmp_val(idle_long, 1'b1, "idle indication");
    $display("idle detect done");
    report_and_stop();
  end
endmodule : usbs_ep0_status_control_tb

`default_nettype wire
